// [bench/bmc_core_props.sv]
// Concurrent checks on the ports of the monitor and mode code core.
// Assumes binding to bmc_core; one clock, asynchronous high reset.
module bmc_core_props import bmc_pkg::*; #(
    parameter int ADDR_W = 16
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic bus_monitor_i,
    input wire logic controller_start_i,
    input wire logic [4:0] terminal_address_inputs_i,
    input wire logic rx_stb_i,
    input wire logic [15:0] rx_data_i,
    input wire logic rx_cmd_sync_i,
    input wire logic rx_err_i,
    input wire logic rx_bus_a_i,
    input wire logic mem_req_o,
    input wire logic mem_we_o,
    input wire logic [ADDR_W-1:0] mem_addr_o,
    input wire logic [15:0] mem_wdata_o,
    input wire logic mem_ack_i,
    input wire logic override_shutdown_i,
    input wire logic reset_terminal_i,
    input wire logic own_address_match_strobe_n_o,
    input wire logic bus_grant_strobe_n_o,
    input wire logic [1:0] tx_disable_o
);
    // Fields of the word taken, last write address, word or id slot
    logic cs_q, er_q, a_q, have_q, pair_q;
    logic [ADDR_W-1:0] last_q;
    wire wr_done = mem_req_o && mem_we_o && mem_ack_i;
    wire own_cmd = rx_stb_i && rx_cmd_sync_i && !rx_err_i &&
        rx_data_i[15:11] == terminal_address_inputs_i;
    // Track what is being stored
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            {cs_q, er_q, a_q, have_q, pair_q} <= 5'h00;
            last_q <= '0;
        end else begin
            if (rx_stb_i && !mem_req_o) {cs_q, er_q, a_q} <= {rx_cmd_sync_i, rx_err_i, rx_bus_a_i};
            if (wr_done) {last_q, have_q, pair_q} <= {mem_addr_o, 1'b1, !pair_q};
        end
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    a_ptr_read_first: assert property (
        $rose(controller_start_i) && bus_monitor_i |-> ##[1:4]
        (mem_req_o && !mem_we_o && mem_addr_o == STACK_PTR_ADDR))
        else $error("pointer location not read after start");
    a_req_held: assert property (
        mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o))
        else $error("memory request dropped before ack");
    a_addr_step: assert property (
        bus_monitor_i && have_q && mem_req_o && mem_we_o |-> mem_addr_o == ADDR_W'(last_q + 1))
        else $error("store address did not step by one");
    a_id_fields: assert property (
        pair_q && mem_req_o && mem_we_o |-> mem_wdata_o[ID_WORD_FLAG] &&
        mem_wdata_o[ID_CMD_SYNC] == cs_q && mem_wdata_o[ID_ERR] == er_q &&
        mem_wdata_o[ID_CHAN_A] == a_q)
        else $error("identification fields wrong");
    a_own_match: assert property (
        own_cmd |-> ##[1:3] !own_address_match_strobe_n_o)
        else $error("own address strobe missing");
    a_own_one_cycle: assert property (
        !own_address_match_strobe_n_o |=> own_address_match_strobe_n_o)
        else $error("own address strobe too long");
    a_grant_one_cycle: assert property (
        !bus_grant_strobe_n_o |=> bus_grant_strobe_n_o)
        else $error("grant strobe too long");
    a_shutdown_hold: assert property (
        (|tx_disable_o) && !override_shutdown_i && !reset_terminal_i |=> (|tx_disable_o))
        else $error("transmitter enabled without override");
    c_start: cover property ($rose(controller_start_i));
    c_own: cover property (!own_address_match_strobe_n_o);
    c_shut: cover property (|tx_disable_o);
endmodule
bind bmc_core bmc_core_props #(.ADDR_W(ADDR_W)) i_bmc_core_props (.*);

// [bench/bmc_mem_model.sv]
// Shared memory model that answers the core's memory port.
// Assumes requests hold until acknowledged; latency is chosen per access.
module bmc_mem_model (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic mem_req_i,
    input wire logic mem_we_i,
    input wire logic [15:0] mem_addr_i,
    input wire logic [15:0] mem_wdata_i,
    input wire logic slow_i,
    output logic mem_ack_o,
    output logic [15:0] mem_rdata_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Storage, filled by the bench before capture starts
    logic [15:0] mem [0:65535];
    int wait_q;
    // Ack after the chosen latency; read data stands only with ack
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mem_ack_o <= 1'b0;
            wait_q <= 0;
            mem_rdata_o <= 16'h0000;
        end else if (mem_req_i && !mem_ack_o && wait_q >= (slow_i ? 3 : 0)) begin
            mem_ack_o <= 1'b1;
            wait_q <= 0;
            if (mem_we_i) mem[mem_addr_i] <= mem_wdata_i;
            else mem_rdata_o <= mem[mem_addr_i];
        end else begin
            mem_ack_o <= 1'b0;
            wait_q <= (mem_req_i && !mem_ack_o) ? wait_q + 1 : 0;
            // Released bus shows a changing pattern
            mem_rdata_o <= ~mem_rdata_o;
        end
    end
endmodule

// [bench/tb.sv]
// Self-checking bench for monitor capture and mode code handling.
// Assumes the core, package, checker and memory model compile first.
module tb import bmc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk_i = 0, rst_i = 1, bus_monitor_i = 0, controller_start_i = 0, mem_slow = 0;
    logic rx_stb_i = 0, rx_cmd_sync_i = 0, rx_err_i = 0, rx_bus_a_i = 0, loop_fail_i = 0;
    logic override_shutdown_i = 0, reset_terminal_i = 0, bus_control_accept_i = 0;
    logic [4:0] terminal_address_inputs_i = 5'h0A;
    logic [15:0] rx_data_i = 16'h0000, mem_rdata_i, mem_addr_o, mem_wdata_o, tx_data_o;
    logic [15:0] status_word_o;
    logic [13:0] bit_events_i = 14'h0000, self_test_o, exp_st;
    logic mem_req_o, mem_we_o, mem_ack_i, own_address_match_strobe_n_o, bus_grant_strobe_n_o;
    logic take_control_o, tx_req_o;
    logic [2:0] subaddr_modecode_outputs_o, exp_sw;
    logic [1:0] tx_disable_o;
    int failures = 0, num_checks = 0, own_cnt = 0, seed = 32'hd04a_bd69;
    bmc_mem_model i_bmc_mem_model (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .mem_req_i(mem_req_o),
        .mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o),
        .slow_i(mem_slow), .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));
    bmc_core #(.ADDR_W(16)) i_bmc_core (.*);
    // Clock of 10 ns
    initial forever #5 ref_clk_i = ~ref_clk_i;
    // Count own address strobes where they are settled
    always @(negedge ref_clk_i) if (own_address_match_strobe_n_o === 1'b0) own_cnt++;
    // Compare one value and count it
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic do_reset;
        @(posedge ref_clk_i);
        rst_i <= 1'b1;
        repeat (10) @(posedge ref_clk_i);
        rst_i <= 1'b0;
    endtask
    // One received word, strobed for a cycle
    task automatic send(input logic [15:0] d, input logic cs, er, ba);
        @(posedge ref_clk_i);
        {rx_data_i, rx_cmd_sync_i, rx_err_i, rx_bus_a_i, rx_stb_i} <= {d, cs, er, ba, 1'b1};
        @(posedge ref_clk_i);
        rx_stb_i <= 1'b0;
    endtask
    // Capture words from a start pointer near the top of memory
    task automatic mon_test;
        logic [15:0] ptr, d, id, mask;
        logic cs, er, ba, ct;
        int n, gap, own0, own_exp;
        i_bmc_mem_model.mem[STACK_PTR_ADDR] = 16'hFFFC;
        @(posedge ref_clk_i);
        {bus_monitor_i, controller_start_i} <= 2'b11;
        @(posedge ref_clk_i);
        controller_start_i <= 1'b0;
        {own0, own_exp, ptr, gap} = {own_cnt, 32'h0000_0000, 16'hFFFC, 32'h0000_0064};
        for (n = 0; n < 70; n++) begin
            {d, cs, er, ba} = {16'($random(seed)), 1'($random(seed)), 1'(($random(seed) & 7) == 0),
                1'($random(seed))};
            if (cs && n % 3 == 0) d[15:11] = terminal_address_inputs_i;
            if (cs && n % 3 == 1) d[15:11] = BCAST_ADDR;
            mem_slow <= $random(seed);
            repeat (gap - 42) @(posedge ref_clk_i);
            send(d, cs, er, ba);
            repeat (40) @(posedge ref_clk_i);
            #1;
            ct = gap < CONTIG_CYC;
            id = {ct ? 8'h00 : (gap > 256 * GAP_STEP_CYC ? GAP_MAX : 8'(gap / GAP_STEP_CYC)), 1'b1,
                !(cs && d[15:11] == terminal_address_inputs_i), !(cs && d[15:11] == BCAST_ADDR),
                er, cs, ba, ct, 1'b0};
            mask = (!cs || er) ? 16'hFF9E : 16'hFFFE;
            if (n == 0) mask &= 16'h00FD;
            chk("stored word", d, i_bmc_mem_model.mem[ptr]);
            chk("id word", id & mask, i_bmc_mem_model.mem[16'(ptr + 1)] & mask);
            chk("count taps", 16'(((n + 1) * 2 >> 5) & 7), 16'(subaddr_modecode_outputs_o));
            ptr = ptr + 16'h0002;
            gap = (n == 4) ? 1010 : (n == 8) ? 15000 : 100;
            if (cs && !er && d[15:11] == terminal_address_inputs_i) own_exp++;
        end
        chk("own strobes", 16'(own_exp), 16'(own_cnt - own0));
        @(posedge ref_clk_i);
        bus_monitor_i <= 1'b0;
    endtask
    // One mode command; rs restarts the terminal first
    task automatic rt_case(input logic [4:0] code, input logic dir, bc, df, er, lf, rs,
            input logic [13:0] ev);
        logic [15:0] w;
        logic ba, rep, gseen;
        int reps;
        ba = $random(seed);
        w = {bc ? BCAST_ADDR : terminal_address_inputs_i, dir, ba ? 5'h1F : 5'h00, code};
        if (rs) do_reset;
        if (rs) {exp_st, exp_sw} = 17'h0_0000;
        @(posedge ref_clk_i);
        {loop_fail_i, bit_events_i, bus_control_accept_i} <= {lf, ev, 1'b0};
        @(posedge ref_clk_i);
        bit_events_i <= 14'h0000;
        @(posedge ref_clk_i);
        {rx_data_i, rx_cmd_sync_i, rx_err_i, rx_bus_a_i, rx_stb_i} <= {w, 1'b1, er, ba, 1'b1};
        // data word strobed right behind the command
        if (df) begin
            @(posedge ref_clk_i);
            {rx_data_i, rx_cmd_sync_i, rx_err_i} <= {16'($random(seed)), 1'b0, 1'b0};
        end
        @(posedge ref_clk_i);
        rx_stb_i <= 1'b0;
        {reps, gseen} = 0;
        repeat (60) begin
            @(posedge ref_clk_i);
            if (gseen) bus_control_accept_i <= 1'b1;
            #1;
            if (tx_req_o === 1'b1) reps++;
            if (bus_grant_strobe_n_o === 1'b0) gseen = 1'b1;
        end
        rep = 1'b0;
        exp_st = exp_st | ev;
        // faulty words and higher codes ignored
        if (!er && code <= MC_SHUTDOWN) begin
            if (df) begin
                {exp_sw[2], exp_st[BIT_HIGH_WC]} = 2'b11;
            end else if (!dir) begin
                {exp_sw[2], exp_st[BIT_DIR_ERR]} = 2'b11;
                exp_sw[1] = exp_sw[1] | bc;
                if (bc && code != MC_SELF_TEST) exp_st[BIT_ILL_MC] = 1'b1;
            end else if (bc) begin
                exp_sw[1] = 1'b1;
                if (code == MC_DBC || code == MC_TX_STATUS) {exp_sw[2], exp_st[BIT_ILL_MC]} = 2'b11;
            end else begin
                rep = 1'b1;
            end
            if (rep && code == MC_SELF_TEST && lf) begin
                {exp_sw[0], exp_st[BIT_AB_LOOP]} = 2'b11;
                exp_st[ba ? BIT_LOOP_A : BIT_LOOP_B] = 1'b1;
            end
        end
        chk("reply", 16'(rep), 16'(reps));
        chk("status", 16'(exp_sw), 16'({status_word_o[SW_MSG_ERR], status_word_o[SW_BCAST],
            status_word_o[SW_TFLAG]}));
        chk("self test", 16'(exp_st), 16'(self_test_o));
        chk("control", 16'(rep && code == MC_DBC), 16'(take_control_o));
        chk("tx disable", (rep && code == MC_SHUTDOWN) ? (ba ? 16'h0001 : 16'h0002) : 16'h0000,
            16'(tx_disable_o));
        if (rep && code == MC_SHUTDOWN) begin
            {override_shutdown_i, reset_terminal_i} <= {ba, !ba};
            @(posedge ref_clk_i);
            {override_shutdown_i, reset_terminal_i} <= 2'b00;
            repeat (3) @(posedge ref_clk_i);
            #1;
            chk("tx enable", 16'h0000, 16'(tx_disable_o));
        end
    endtask
    // Verdict and end of run
    task automatic results;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Watchdog well beyond the expected run length
    initial begin
        repeat (100000) @(posedge ref_clk_i);
        failures++;
        results;
    end
    // Main sequence
    initial begin
        int c, k;
        do_reset;
        mon_test;
        $display("monitor capture test done");
        for (c = 0; c < 6; c++) begin
            for (k = 0; k < 4; k++) rt_case(c[4:0], k[0], k[1], 1'b0, 1'b0, 1'($random(seed)),
                1'b1, 14'h0000);
            rt_case(c[4:0], 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 14'h0000);
        end
        rt_case(MC_SYNC, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 14'h0000);
        rt_case(MC_SELF_TEST, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 14'h0000);
        rt_case(MC_TX_STATUS, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 14'h0000);
        rt_case(MC_SYNC, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 14'($random(seed)));
        $display("mode code test done");
        results;
    end
endmodule

// [src/bmc_core.sv]
// Bus monitor capture and remote terminal mode codes 00000..00100.
// Assumes decoded received words, a shared RAM port and loop test result.
//
// Contract
// - Storage pointer wraps to zero at end
// - Controller start reads pointer location first
// - Store word, advance, store identification
// - Gap field in half-microseconds, saturates
// - Active-low own-address and broadcast flags
// - Error bit for received word faults
// - Sync bit one for command sync
// - Channel bit one for bus A
// - Contiguous bit within two microseconds
// - Pulse low on own valid command
// - Taps toggle at 32, 64, 128 words
// - Fourteen-bit self-test word, held until reset
// - Sync without data replies, broadcast suppresses
// - Transmit status leaves registers unchanged
// - Self-test reply loops, failure sets flags
// - Shutdown disables redundant transmitter until override or terminal reset
// - Invalid command ignored, no reply
// - Data after mode: no reply, errors
// - Cleared direction: no reply, errors
// - Direction plus broadcast: no reply, errors
// - Broadcast transmit-only code: no reply
module bmc_core import bmc_pkg::*; #(
    parameter int ADDR_W = 16
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Mode selection and start
    input wire logic bus_monitor_i,
    input wire logic controller_start_i,
    input wire logic [4:0] terminal_address_inputs_i,
    // Received word from the decoders
    input wire logic rx_stb_i,
    input wire logic [15:0] rx_data_i,
    input wire logic rx_cmd_sync_i,
    input wire logic rx_err_i,
    input wire logic rx_bus_a_i,
    // Shared RAM port
    output logic mem_req_o,
    output logic mem_we_o,
    output logic [ADDR_W-1:0] mem_addr_o,
    output logic [15:0] mem_wdata_o,
    input wire logic mem_ack_i,
    input wire logic [15:0] mem_rdata_i,
    // Remote terminal side
    input wire logic override_shutdown_i,
    input wire logic reset_terminal_i,
    input wire logic loop_fail_i,
    input wire logic [13:0] bit_events_i,
    input wire logic bus_control_accept_i,
    output logic own_address_match_strobe_n_o,
    output logic bus_grant_strobe_n_o,
    output logic take_control_o,
    output logic [2:0] subaddr_modecode_outputs_o,
    output logic tx_req_o,
    output logic [15:0] tx_data_o,
    output logic [1:0] tx_disable_o,
    output logic [15:0] status_word_o,
    output logic [13:0] self_test_o
);
    initial begin
        if (ADDR_W < 8 || ADDR_W > 16) $error("ADDR_W out of range");
    end

    typedef enum logic [2:0] {
        BMC_IDLE, BMC_RD_PTR, BMC_WAIT, BMC_WR_WORD, BMC_WR_ID
    } bmc_mt_state_t;

    localparam int ACCEPT_NS = 2500;
    localparam int ACCEPT_CYC = ACCEPT_NS * CLK_MHZ / 1000;

    // Monitor state, pointer, latched word and its id fields
    bmc_mt_state_t state_q;
    logic [ADDR_W-1:0] ptr_q;
    logic [15:0] word_q;
    logic [15:0] id_q;
    logic [7:0] count_q;
    logic [7:0] gap_w;
    logic contig_w;

    // Word timing
    bmc_gap_timer u_gap (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .word_stb_i(rx_stb_i),
        .gap_o(gap_w),
        .contig_o(contig_w)
    );

    // Received word fields
    wire [4:0] rx_addr_w = rx_data_i[15:11];
    wire rx_tx_w = rx_data_i[10];
    wire [4:0] rx_sa_w = rx_data_i[9:5];
    wire [4:0] rx_code_w = rx_data_i[4:0];
    wire rx_mode_w = (rx_sa_w == 5'h00) || (rx_sa_w == 5'h1F);
    wire rx_own_w = (rx_addr_w == terminal_address_inputs_i);
    wire rx_bc_w = (rx_addr_w == BCAST_ADDR);
    wire valid_cmd_w = rx_stb_i && rx_cmd_sync_i && !rx_err_i;

    // Identification word built from the current word
    logic [15:0] id_w;
    always_comb begin
        id_w = '0;
        id_w[15:ID_GAP_LSB] = contig_w ? 8'h00 : gap_w;
        id_w[ID_WORD_FLAG] = 1'b1;
        id_w[ID_OWN] = !(rx_cmd_sync_i && rx_own_w);
        id_w[ID_BCAST] = !(rx_cmd_sync_i && rx_bc_w);
        id_w[ID_ERR] = rx_err_i;
        id_w[ID_CMD_SYNC] = rx_cmd_sync_i;
        id_w[ID_CHAN_A] = rx_bus_a_i;
        id_w[ID_CONTIG] = contig_w;
        id_w[ID_MODE] = rx_cmd_sync_i && rx_mode_w;
    end

    // Capture sequencer
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= BMC_IDLE;
            ptr_q <= '0;
            word_q <= '0;
            id_q <= '0;
            count_q <= '0;
        end else begin
            case (state_q)
                BMC_IDLE: begin
                    if (bus_monitor_i && controller_start_i) begin
                        state_q <= BMC_RD_PTR;
                    end
                end
                BMC_RD_PTR: begin
                    if (mem_ack_i) begin
                        ptr_q <= mem_rdata_i[ADDR_W-1:0];
                        state_q <= BMC_WAIT;
                    end
                end
                BMC_WAIT: begin
                    if (rx_stb_i) begin
                        word_q <= rx_data_i;
                        id_q <= id_w;
                        state_q <= BMC_WR_WORD;
                    end
                end
                BMC_WR_WORD: begin
                    if (mem_ack_i) begin
                        ptr_q <= ptr_q + 1'b1;
                        state_q <= BMC_WR_ID;
                    end
                end
                BMC_WR_ID: begin
                    if (mem_ack_i) begin
                        ptr_q <= ptr_q + 1'b1;
                        count_q <= count_q + 8'h02;
                        state_q <= BMC_WAIT;
                    end
                end
                default: state_q <= BMC_IDLE;
            endcase
        end
    end

    // Memory port decode
    assign mem_req_o = (state_q == BMC_RD_PTR) || (state_q == BMC_WR_WORD)
                       || (state_q == BMC_WR_ID);
    assign mem_we_o = (state_q != BMC_RD_PTR) && mem_req_o;
    assign mem_addr_o = (state_q == BMC_RD_PTR) ? STACK_PTR_ADDR[ADDR_W-1:0] : ptr_q;
    assign mem_wdata_o = (state_q == BMC_WR_ID) ? id_q : word_q;

    // taps at 32, 64, 128 words
    assign subaddr_modecode_outputs_o = count_q[7:5];

    // Remote terminal command path
    logic own_q;
    logic pend_q;
    logic [15:0] cmd_q;
    logic [15:0] sw_q;
    logic [13:0] bit_q;
    logic [1:0] shut_q;
    logic grant_q;
    logic [7:0] acc_cnt_q;
    logic take_q;
    logic reply_w, msg_err_w, bcs_w, hwc_w, dir_w, ill_w;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            own_q <= 1'b0;
        end else begin
            own_q <= valid_cmd_w && rx_own_w;
        end
    end
    assign own_address_match_strobe_n_o = !own_q;

    // Data word right after a pending mode command
    wire data_follow_w = rx_stb_i && !rx_cmd_sync_i && !rx_err_i;
    wire eval_w = pend_q && (rx_stb_i || !bus_monitor_i);

    bmc_mode_decode u_dec (
        .code_i(cmd_q[4:0]),
        .dir_tx_i(cmd_q[10]),
        .bcast_i(cmd_q[15:11] == BCAST_ADDR),
        .data_follow_i(data_follow_w),
        .reply_o(reply_w),
        .msg_err_o(msg_err_w),
        .bcast_set_o(bcs_w),
        .high_wc_o(hwc_w),
        .dir_err_o(dir_w),
        .ill_mc_o(ill_w)
    );

    wire is_code_w = (cmd_q[4:0] <= MC_SHUTDOWN);
    wire [4:0] code_w = cmd_q[4:0];
    wire loop_active_w = reply_w && (code_w == MC_SELF_TEST);

    // Mode command evaluation and status keeping
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pend_q <= 1'b0;
            cmd_q <= '0;
            sw_q <= '0;
            bit_q <= '0;
            shut_q <= '0;
            tx_req_o <= 1'b0;
            tx_data_o <= '0;
            grant_q <= 1'b0;
        end else begin
            tx_req_o <= 1'b0;
            grant_q <= 1'b0;
            bit_q <= bit_q | bit_events_i;
            // only valid own or broadcast mode commands
            if (valid_cmd_w && !pend_q && !bus_monitor_i && (rx_own_w || rx_bc_w)
                && rx_mode_w) begin
                pend_q <= 1'b1;
                cmd_q <= {rx_addr_w, rx_tx_w, rx_sa_w, rx_code_w};
            end else if (eval_w && is_code_w) begin
                pend_q <= 1'b0;
                if (!(reply_w && code_w == MC_TX_STATUS)) begin
                    sw_q[SW_MSG_ERR] <= msg_err_w;
                    sw_q[SW_BCAST] <= bcs_w;
                end
                // Keep a same-cycle external event on these bits too
                bit_q[BIT_HIGH_WC] <= bit_q[BIT_HIGH_WC] | bit_events_i[BIT_HIGH_WC] | hwc_w;
                bit_q[BIT_DIR_ERR] <= bit_q[BIT_DIR_ERR] | bit_events_i[BIT_DIR_ERR] | dir_w;
                bit_q[BIT_ILL_MC] <= bit_q[BIT_ILL_MC] | bit_events_i[BIT_ILL_MC] | ill_w;
                tx_req_o <= reply_w;
                tx_data_o <= sw_q;
                grant_q <= reply_w && (code_w == MC_DBC);
                if (reply_w && code_w == MC_SHUTDOWN) begin
                    // Bits are {A,B}: the channel not carrying the command goes quiet
                    shut_q <= rx_bus_a_i ? 2'b01 : 2'b10;
                end
                if (loop_active_w && loop_fail_i) begin
                    sw_q[SW_TFLAG] <= 1'b1;
                    bit_q[BIT_AB_LOOP] <= 1'b1;
                    bit_q[rx_bus_a_i ? BIT_LOOP_A : BIT_LOOP_B] <= 1'b1;
                end
            end else if (eval_w) begin
                pend_q <= 1'b0;
            end
            if (override_shutdown_i || reset_terminal_i) begin
                shut_q <= '0;
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            acc_cnt_q <= '0;
            take_q <= 1'b0;
        end else if (grant_q) begin
            acc_cnt_q <= 8'(ACCEPT_CYC);
        end else if (acc_cnt_q != 8'h00) begin
            acc_cnt_q <= acc_cnt_q - 8'h01;
            if (bus_control_accept_i) begin
                take_q <= 1'b1;
            end
        end
    end

    assign bus_grant_strobe_n_o = !grant_q;
    assign take_control_o = take_q;
    assign tx_disable_o = shut_q;
    assign status_word_o = sw_q;
    assign self_test_o = bit_q;
endmodule

// [src/bmc_gap_timer.sv]
// Measures the time between received words in half-microsecond steps.
// Assumes word_stb_i pulses for one cycle per received word.
module bmc_gap_timer import bmc_pkg::*; (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic word_stb_i,
    output logic [7:0] gap_o,
    output logic contig_o
);
    // Sub-step prescaler and step counter
    logic [7:0] pre_q;
    logic [7:0] steps_q;
    logic [15:0] cyc_q;
    wire step_w = (pre_q == 8'(GAP_STEP_CYC - 1));

    // Count cycles and steps, restart on each word
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pre_q <= '0;
            steps_q <= GAP_MAX;
            cyc_q <= 16'hFFFF;
        end else if (word_stb_i) begin
            pre_q <= '0;
            steps_q <= '0;
            cyc_q <= '0;
        end else begin
            pre_q <= step_w ? 8'h00 : pre_q + 8'h01;
            if (step_w && steps_q != GAP_MAX) begin
                steps_q <= steps_q + 8'h01;
            end
            if (cyc_q != 16'hFFFF) begin
                cyc_q <= cyc_q + 16'h0001;
            end
        end
    end

    // Values at the arriving word
    assign gap_o = steps_q;
    assign contig_o = (cyc_q < 16'(CONTIG_CYC));
endmodule

// [src/bmc_mode_decode.sv]
// Classifies a mode command and its error cases into flag updates.
// Assumes inputs stand while the command is evaluated.
module bmc_mode_decode import bmc_pkg::*; (
    input wire logic [4:0] code_i,
    input wire logic dir_tx_i,
    input wire logic bcast_i,
    input wire logic data_follow_i,
    output logic reply_o,
    output logic msg_err_o,
    output logic bcast_set_o,
    output logic high_wc_o,
    output logic dir_err_o,
    output logic ill_mc_o
);
    wire tx_only_w = (code_i == MC_DBC) || (code_i == MC_TX_STATUS);
    wire is_st_w = (code_i == MC_SELF_TEST);

    // Priority: data word, direction, broadcast misuse, normal
    always_comb begin
        reply_o = 1'b0;
        msg_err_o = 1'b0;
        bcast_set_o = 1'b0;
        high_wc_o = 1'b0;
        dir_err_o = 1'b0;
        ill_mc_o = 1'b0;
        if (data_follow_i) begin
            msg_err_o = 1'b1;
            high_wc_o = 1'b1;
        end else if (!dir_tx_i) begin
            msg_err_o = 1'b1;
            dir_err_o = 1'b1;
            bcast_set_o = bcast_i;
            ill_mc_o = bcast_i && !is_st_w;
        end else if (bcast_i && tx_only_w) begin
            msg_err_o = 1'b1;
            bcast_set_o = 1'b1;
            ill_mc_o = 1'b1;
        end else if (bcast_i) begin
            bcast_set_o = 1'b1;
        end else begin
            reply_o = 1'b1;
        end
    end
endmodule

// [src/bmc_pkg.sv]
// Shared constants for the bus monitor and mode code logic.
// Assumes a 100 MHz system clock and decoded words from the receivers.
package bmc_pkg;
    // Clock rate and times
    localparam int CLK_MHZ = 100;
    localparam int GAP_STEP_NS = 500;
    localparam int GAP_STEP_CYC = GAP_STEP_NS * CLK_MHZ / 1000;
    localparam int CONTIG_NS = 2000;
    localparam int CONTIG_CYC = CONTIG_NS * CLK_MHZ / 1000;
    localparam logic [7:0] GAP_MAX = 8'hFF;
    localparam logic [7:0] GAP_LIMIT = 8'h00FF;
    // Memory layout
    localparam logic [15:0] STACK_PTR_ADDR = 16'h0100;
    localparam logic [15:0] WRAP_ADDR = 16'h0000;
    // Broadcast address
    localparam logic [4:0] BCAST_ADDR = 5'h1F;
    // Mode codes handled
    localparam logic [4:0] MC_DBC = 5'h00;
    localparam logic [4:0] MC_SYNC = 5'h01;
    localparam logic [4:0] MC_TX_STATUS = 5'h02;
    localparam logic [4:0] MC_SELF_TEST = 5'h03;
    localparam logic [4:0] MC_SHUTDOWN = 5'h04;
    // Status word bits
    localparam int SW_MSG_ERR = 10;
    localparam int SW_BCAST = 4;
    localparam int SW_TFLAG = 0;
    // Self test word bits
    localparam int BIT_TX_TIMEOUT_A = 0;
    localparam int BIT_TX_TIMEOUT_B = 1;
    localparam int BIT_LOOP_A = 2;
    localparam int BIT_LOOP_B = 3;
    localparam int BIT_SHUTDOWN_A = 4;
    localparam int BIT_SHUTDOWN_B = 5;
    localparam int BIT_HANDSHAKE = 6;
    localparam int BIT_DIR_ERR = 7;
    localparam int BIT_ILL_MC = 8;
    localparam int BIT_LOW_WC = 9;
    localparam int BIT_HIGH_WC = 10;
    localparam int BIT_AB_LOOP = 11;
    // Identification word fields
    localparam int ID_GAP_LSB = 8;
    localparam int ID_WORD_FLAG = 7;
    localparam int ID_OWN = 6;
    localparam int ID_BCAST = 5;
    localparam int ID_ERR = 4;
    localparam int ID_CMD_SYNC = 3;
    localparam int ID_CHAN_A = 2;
    localparam int ID_CONTIG = 1;
    localparam int ID_MODE = 0;
endpackage
